// file: src/sdt_pkg.sv
package sdt_pkg;
  // Register byte offsets, one 32-bit word each
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0c;
  localparam logic [7:0] OFF_RELOAD = 8'h10;
  localparam logic [7:0] OFF_CAPTURE = 8'h14;

  // Control register fields
  localparam int CTRL_W = 8;
  localparam int B_SPLIT = 0;
  localparam int B_RUN = 1;
  localparam int B_EXTSEL = 2;
  localparam int B_HSYS = 3;
  localparam int B_LSYS = 4;
  localparam int B_LFIE = 5;
  localparam int B_IE = 6;
  localparam int B_CAPEN = 7;

  // Status and mask fields
  localparam int STAT_W = 3;
  localparam int F_LOW = 0;
  localparam int F_HIGH = 1;
  localparam int F_CAP = 2;

  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic [STAT_W-1:0] STAT_RST = 3'h0;
  localparam logic [STAT_W-1:0] MASK_RST = 3'h7;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] RELOAD_RST = 16'h0000;
  localparam logic [7:0] HALF_MAX = 8'hff;
  localparam logic [15:0] FULL_MAX = 16'hffff;

  // Prescaler ratios
  localparam int SYS_DIV = 12;
  localparam int EXT_DIV = 8;
endpackage : sdt_pkg

// file: src/sdt_tick_gen.sv
`timescale 1ns/1ps
module sdt_tick_gen #(
  parameter int SYS_DIV = sdt_pkg::SYS_DIV,
  parameter int EXT_DIV = sdt_pkg::EXT_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ext_clk_i,
  output logic div_sys_o,
  output logic div_ext_o
);
  localparam int SW = $clog2(SYS_DIV);
  localparam int EW = $clog2(EXT_DIV);
  localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIV - 1);
  localparam logic [EW-1:0] EXT_LAST = EW'(EXT_DIV - 1);
  localparam logic [SW-1:0] SYS_ONE = SW'(1);
  localparam logic [EW-1:0] EXT_ONE = EW'(1);

  logic sync1;
  logic sync2;
  logic sync3;
  logic [SW-1:0] cnt_sys;
  logic [EW-1:0] cnt_ext;
  logic next_sync3;
  logic [SW-1:0] next_cnt_sys;
  logic [EW-1:0] next_cnt_ext;
  logic next_div_sys;
  logic next_div_ext;
  logic ext_rise;

  always_comb
  begin
    // Edge taken after the second stage only; first stage is metastable
    ext_rise = sync2 & ~sync3;
    next_sync3 = sync2;
    next_div_sys = 1'b0;
    next_div_ext = 1'b0;
    next_cnt_ext = cnt_ext;
    if (cnt_sys == SYS_LAST)
    begin
      next_cnt_sys = '0;
      next_div_sys = 1'b1;
    end
    else
    begin
      next_cnt_sys = cnt_sys + SYS_ONE;
    end
    if (ext_rise)
    begin
      if (cnt_ext == EXT_LAST)
      begin
        next_cnt_ext = '0;
        next_div_ext = 1'b1;
      end
      else
      begin
        next_cnt_ext = cnt_ext + EXT_ONE;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      sync3 <= 1'b0;
      cnt_sys <= '0;
      cnt_ext <= '0;
      div_sys_o <= 1'b0;
      div_ext_o <= 1'b0;
    end
    else
    begin
      sync1 <= ext_clk_i;
      sync2 <= sync1;
      sync3 <= next_sync3;
      cnt_sys <= next_cnt_sys;
      cnt_ext <= next_cnt_ext;
      div_sys_o <= next_div_sys;
      div_ext_o <= next_div_ext;
    end
  end

  AST_DIV_SYS_PERIOD: assert property (@(posedge clk_i) disable iff (rst_i)
    div_sys_o |-> ##12 div_sys_o)
    else $error("system divider period wrong");

  AST_DIV_SYS_GAP: assert property (@(posedge clk_i) disable iff (rst_i)
    div_sys_o |=> !div_sys_o [*8])
    else $error("system divider ticks too close");
endmodule : sdt_tick_gen

// file: src/sdt_split_timer.sv
// Summary of operation
// - Split bit set makes the timer two independent 8-bit halves.
// - In split mode each half reloads from its reload value on overflow.
// - Low reload feeds the low half, high reload feeds the high half.
// - In split mode the run bit gates only the high half.
// - In split mode the low half always counts.
// - Clock sources: system clock, system clock over 12, external over 8.
// - System_clock select bit picks system clock, else external select picks divider.
// - High overflow flag sets when high half steps past ff and reloads.
// - Low overflow flag sets when low half steps past ff and reloads.
// - With interrupts enabled, each high overflow raises the interrupt.
// - With low flag interrupt enable too, either half's overflow interrupts.
// - Hardware never clears overflow flags; software writes them clear.
// - Capture mode latches the count on comparator rising edges.
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module sdt_split_timer #(
  parameter int SYS_DIV = sdt_pkg::SYS_DIV,
  parameter int EXT_DIV = sdt_pkg::EXT_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_clk_i,
  input wire logic comp_i,
  output logic irq_o
);
  logic [sdt_pkg::CTRL_W-1:0] ctrl;
  logic [sdt_pkg::STAT_W-1:0] status;
  logic [sdt_pkg::STAT_W-1:0] mask;
  logic [7:0] low_counter_half;
  logic [7:0] high_counter_half;
  logic [7:0] low_reload_value;
  logic [7:0] high_reload_value;
  logic [15:0] capture;
  logic comp_q;

  logic [sdt_pkg::CTRL_W-1:0] next_ctrl;
  logic [sdt_pkg::STAT_W-1:0] next_status;
  logic [sdt_pkg::STAT_W-1:0] next_mask;
  logic [7:0] next_low;
  logic [7:0] next_high;
  logic [7:0] next_low_reload;
  logic [7:0] next_high_reload;
  logic [15:0] next_capture;
  logic [31:0] next_dat;
  logic next_ack;
  logic next_irq;

  logic div_sys;
  logic div_ext;
  logic split_mode_select;
  logic high_run_enable;
  logic external_clock_select;
  logic tick_low;
  logic tick_high;
  logic req;
  logic wr;
  logic count_wr;
  logic status_wr;
  logic low_ovf;
  logic high_ovf;
  logic cap_ev;
  logic [8:0] inc_low;
  logic [8:0] inc_high;
  logic [16:0] inc_full;
  logic [31:0] wmerge;

  // Byte-lane merge of a write into the old contents
  function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_sel

  // Increment with carry out
  function automatic logic [8:0] inc8(input logic [7:0] v);
    return {1'b0, v} + 9'h001;
  endfunction : inc8

  sdt_tick_gen #(
    .SYS_DIV(SYS_DIV),
    .EXT_DIV(EXT_DIV)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ext_clk_i(ext_clk_i),
    .div_sys_o(div_sys),
    .div_ext_o(div_ext)
  );

  assign split_mode_select = ctrl[sdt_pkg::B_SPLIT];
  assign high_run_enable = ctrl[sdt_pkg::B_RUN];
  assign external_clock_select = ctrl[sdt_pkg::B_EXTSEL];
  assign req = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where ack is seen high
  assign wr = req & wb_ack_o & wb_we_i;
  assign count_wr = wr && (wb_adr_i == sdt_pkg::OFF_COUNT);
  assign status_wr = wr && (wb_adr_i == sdt_pkg::OFF_STATUS);
  assign tick_high = ctrl[sdt_pkg::B_HSYS] ? 1'b1 : (external_clock_select ? div_ext : div_sys);
  assign tick_low = ctrl[sdt_pkg::B_LSYS] ? 1'b1 : (external_clock_select ? div_ext : div_sys);
  assign inc_low = inc8(low_counter_half);
  assign inc_high = inc8(high_counter_half);
  assign inc_full = {1'b0, high_counter_half, low_counter_half} + 17'h00001;

  always_comb
  begin
    next_ctrl = ctrl;
    next_mask = mask;
    next_low = low_counter_half;
    next_high = high_counter_half;
    next_low_reload = low_reload_value;
    next_high_reload = high_reload_value;
    next_capture = capture;
    next_dat = wb_dat_o;
    low_ovf = 1'b0;
    high_ovf = 1'b0;
    cap_ev = 1'b0;
    wmerge = 32'h00000000;
    next_ack = req & ~wb_ack_o;
    if (req & ~wb_ack_o)
    begin
      unique case (wb_adr_i)
        sdt_pkg::OFF_CTRL: next_dat = {24'h000000, ctrl};
        sdt_pkg::OFF_STATUS: next_dat = {29'h00000000, status};
        sdt_pkg::OFF_MASK: next_dat = {29'h00000000, mask};
        sdt_pkg::OFF_COUNT: next_dat = {16'h0000, high_counter_half, low_counter_half};
        sdt_pkg::OFF_RELOAD: next_dat = {16'h0000, high_reload_value, low_reload_value};
        sdt_pkg::OFF_CAPTURE: next_dat = {16'h0000, capture};
        default: next_dat = 32'h00000000;
      endcase
    end
    if (split_mode_select)
    begin
      if (tick_low)
      begin
        if (inc_low[8])
        begin
          next_low = low_reload_value;
          low_ovf = 1'b1;
        end
        else
        begin
          next_low = inc_low[7:0];
        end
      end
      if (high_run_enable && tick_high)
      begin
        if (inc_high[8])
        begin
          next_high = high_reload_value;
          high_ovf = 1'b1;
        end
        else
        begin
          next_high = inc_high[7:0];
        end
      end
    end
    else if (high_run_enable && tick_high)
    begin
      // Joined mode: one 16-bit reload counter reporting on the high flag
      if (inc_full[16])
      begin
        {next_high, next_low} = {high_reload_value, low_reload_value};
        high_ovf = 1'b1;
      end
      else
      begin
        {next_high, next_low} = inc_full[15:0];
      end
    end
    // Capture sees the count before this cycle's step
    if (ctrl[sdt_pkg::B_CAPEN] && comp_i && !comp_q)
    begin
      next_capture = {high_counter_half, low_counter_half};
      cap_ev = 1'b1;
    end
    if (wr)
    begin
      unique case (wb_adr_i)
        sdt_pkg::OFF_CTRL:
        begin
          wmerge = merge_sel({24'h000000, ctrl}, wb_dat_i, wb_sel_i);
          next_ctrl = wmerge[sdt_pkg::CTRL_W-1:0];
        end
        sdt_pkg::OFF_STATUS:
        begin
          wmerge = merge_sel(32'h00000000, wb_dat_i, wb_sel_i);
        end
        sdt_pkg::OFF_MASK:
        begin
          wmerge = merge_sel({29'h00000000, mask}, wb_dat_i, wb_sel_i);
          next_mask = wmerge[sdt_pkg::STAT_W-1:0];
        end
        sdt_pkg::OFF_COUNT:
        begin
          // Software load wins over a tick in the same cycle
          wmerge = merge_sel({16'h0000, high_counter_half, low_counter_half}, wb_dat_i,
                             wb_sel_i);
          {next_high, next_low} = wmerge[15:0];
        end
        sdt_pkg::OFF_RELOAD:
        begin
          wmerge = merge_sel({16'h0000, high_reload_value, low_reload_value}, wb_dat_i,
                             wb_sel_i);
          {next_high_reload, next_low_reload} = wmerge[15:0];
        end
        default:
        begin
          wmerge = 32'h00000000;
        end
      endcase
    end
    // Write-one-to-clear only; a same-cycle event still sets the flag
    next_status = status;
    if (status_wr)
    begin
      next_status = status & ~wmerge[sdt_pkg::STAT_W-1:0];
    end
    next_status[sdt_pkg::F_LOW] = next_status[sdt_pkg::F_LOW] | low_ovf;
    next_status[sdt_pkg::F_HIGH] = next_status[sdt_pkg::F_HIGH] | high_ovf;
    next_status[sdt_pkg::F_CAP] = next_status[sdt_pkg::F_CAP] | cap_ev;
    // Low flag only interrupts when enabled; software must read both flags
    next_irq = ctrl[sdt_pkg::B_IE] &
               ((status[sdt_pkg::F_HIGH] & mask[sdt_pkg::F_HIGH]) |
                (ctrl[sdt_pkg::B_LFIE] & status[sdt_pkg::F_LOW] & mask[sdt_pkg::F_LOW]) |
                (status[sdt_pkg::F_CAP] & mask[sdt_pkg::F_CAP]));
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= sdt_pkg::CTRL_RST;
      status <= sdt_pkg::STAT_RST;
      mask <= sdt_pkg::MASK_RST;
      {high_counter_half, low_counter_half} <= sdt_pkg::COUNT_RST;
      {high_reload_value, low_reload_value} <= sdt_pkg::RELOAD_RST;
      capture <= sdt_pkg::COUNT_RST;
      comp_q <= 1'b0;
      wb_dat_o <= 32'h00000000;
      wb_ack_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      ctrl <= next_ctrl;
      status <= next_status;
      mask <= next_mask;
      low_counter_half <= next_low;
      high_counter_half <= next_high;
      low_reload_value <= next_low_reload;
      high_reload_value <= next_high_reload;
      capture <= next_capture;
      comp_q <= comp_i;
      wb_dat_o <= next_dat;
      wb_ack_o <= next_ack;
      irq_o <= next_irq;
    end
  end

  AST_LOW_FREE_RUN: assert property (@(posedge clk_i) disable iff (rst_i)
    split_mode_select && !high_run_enable && tick_low && !count_wr &&
    low_counter_half != sdt_pkg::HALF_MAX |=> low_counter_half == $past(low_counter_half) + 8'h01)
    else $error("low half did not step while run bit clear");

  AST_LOW_RELOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    split_mode_select && tick_low && !count_wr && low_counter_half == sdt_pkg::HALF_MAX
    |=> low_counter_half == $past(low_reload_value))
    else $error("low half did not reload");

  AST_HIGH_RELOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    split_mode_select && high_run_enable && tick_high && !count_wr &&
    high_counter_half == sdt_pkg::HALF_MAX |=> high_counter_half == $past(high_reload_value))
    else $error("high half did not reload");

  AST_HIGH_STOPPED: assert property (@(posedge clk_i) disable iff (rst_i)
    split_mode_select && !high_run_enable && !count_wr |=> $stable(high_counter_half))
    else $error("high half moved while stopped");

  AST_HIGH_SYSTEM_CLOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    split_mode_select && high_run_enable && ctrl[sdt_pkg::B_HSYS] && !count_wr &&
    high_counter_half != sdt_pkg::HALF_MAX [*2] |=>
    high_counter_half == $past(high_counter_half) + 8'h01)
    else $error("high half not on system clock");

  AST_HIGH_FLAG: assert property (@(posedge clk_i) disable iff (rst_i)
    high_ovf |=> status[sdt_pkg::F_HIGH])
    else $error("high overflow flag not set");

  AST_LOW_FLAG: assert property (@(posedge clk_i) disable iff (rst_i)
    low_ovf |=> status[sdt_pkg::F_LOW])
    else $error("low overflow flag not set");

  AST_NO_HW_CLEAR: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(status[sdt_pkg::F_HIGH]) || $fell(status[sdt_pkg::F_LOW]) |->
    $past(status_wr))
    else $error("overflow flag cleared without a write");

  AST_IRQ_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl[sdt_pkg::B_IE] && status[sdt_pkg::F_HIGH] && mask[sdt_pkg::F_HIGH] |=> irq_o)
    else $error("high overflow did not interrupt");

  AST_IRQ_LOW_GATED: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctrl[sdt_pkg::B_LFIE] && !status[sdt_pkg::F_HIGH] && !status[sdt_pkg::F_CAP] |=> !irq_o)
    else $error("low flag interrupted while not enabled");

  AST_CAPTURE: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl[sdt_pkg::B_CAPEN] && comp_i && !comp_q |=>
    capture[15:8] == $past(high_counter_half) && capture[7:0] == $past(low_counter_half) &&
    status[sdt_pkg::F_CAP])
    else $error("capture did not latch count");
endmodule : sdt_split_timer

// file: verification/sdt_split_timer_bench.sv
`timescale 1ns/1ps
module sdt_split_timer_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic ext_clk = 1'b0;
  logic comp = 1'b0;
  logic irq;
  logic [31:0] q;
  int err_total = 0;
  int samples_checked = 0;

  sdt_split_timer #(.SYS_DIV(sdt_pkg::SYS_DIV), .EXT_DIV(sdt_pkg::EXT_DIV)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_clk_i(ext_clk), .comp_i(comp), .irq_o(irq)
  );

  always #5 clk_i = ~clk_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  // One classic cycle; waits on ack with a bound instead of assuming latency
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    q = rdat;
    if (n >= 50)
      check(32'h0, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0, 4'hf);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle

  task automatic t_reset_values();
    rd(sdt_pkg::OFF_CTRL); check(q, 32'h0);
    rd(sdt_pkg::OFF_STATUS); check(q, 32'h0);
    rd(sdt_pkg::OFF_MASK); check(q, 32'h7);
    rd(sdt_pkg::OFF_COUNT); check(q, 32'h0);
    rd(sdt_pkg::OFF_RELOAD); check(q, 32'h0);
    rd(sdt_pkg::OFF_CAPTURE); check(q, 32'h0);
    rd(8'h18); check(q, 32'h0);
    wb(1'b1, sdt_pkg::OFF_RELOAD, 32'h0000_aaaa, 4'h2);
    rd(sdt_pkg::OFF_RELOAD); check(q, 32'h0000_aa00);
  endtask : t_reset_values

  task automatic t_clock_sources();
    // Split, low half on system clock over 12
    wr(sdt_pkg::OFF_CTRL, 32'h01);
    wr(sdt_pkg::OFF_COUNT, 32'h0);
    idle(120);
    rd(sdt_pkg::OFF_COUNT);
    check({31'h0, q[7:0] >= 8'h08 && q[7:0] <= 8'h0b}, 32'h1);
    check({24'h0, q[15:8]}, 32'h0);
    // External clock over 8
    wr(sdt_pkg::OFF_CTRL, 32'h05);
    wr(sdt_pkg::OFF_COUNT, 32'h0);
    repeat (128)
    begin
      idle(2);
      ext_clk <= ~ext_clk;
    end
    idle(10);
    rd(sdt_pkg::OFF_COUNT);
    check({31'h0, q[7:0] >= 8'h07 && q[7:0] <= 8'h08}, 32'h1);
    // System clock
    wr(sdt_pkg::OFF_CTRL, 32'h11);
    wr(sdt_pkg::OFF_COUNT, 32'h0);
    // Three ticks land before the read is taken
    idle(2);
    rd(sdt_pkg::OFF_COUNT);
    check({24'h0, q[7:0]}, 32'h03);
  endtask : t_clock_sources

  task automatic t_low_overflow_irq();
    wr(sdt_pkg::OFF_RELOAD, 32'h0000_e0f0);
    wr(sdt_pkg::OFF_CTRL, 32'h51);
    wr(sdt_pkg::OFF_COUNT, 32'h0000_00f0);
    idle(40);
    rd(sdt_pkg::OFF_STATUS); check(q & 32'h3, 32'h1);
    check({31'h0, irq}, 32'h0);
    rd(sdt_pkg::OFF_COUNT);
    check({31'h0, q[7:0] >= 8'hf0}, 32'h1);
    wr(sdt_pkg::OFF_CTRL, 32'h71);
    idle(4);
    check({31'h0, irq}, 32'h1);
    wr(sdt_pkg::OFF_MASK, 32'h6);
    idle(4);
    check({31'h0, irq}, 32'h0);
    wr(sdt_pkg::OFF_MASK, 32'h7);
    // Non-split with run off freezes the counter so the flag can be cleared
    wr(sdt_pkg::OFF_CTRL, 32'h60);
    idle(30);
    rd(sdt_pkg::OFF_STATUS); check(q & 32'h3, 32'h1);
    wr(sdt_pkg::OFF_STATUS, 32'h1);
    rd(sdt_pkg::OFF_STATUS); check(q, 32'h0);
    idle(3);
    check({31'h0, irq}, 32'h0);
  endtask : t_low_overflow_irq

  task automatic t_high_half();
    wr(sdt_pkg::OFF_CTRL, 32'h49);
    wr(sdt_pkg::OFF_COUNT, 32'h0000_3300);
    idle(30);
    rd(sdt_pkg::OFF_COUNT); check({24'h0, q[15:8]}, 32'h33);
    rd(sdt_pkg::OFF_STATUS); check(q & 32'h2, 32'h0);
    wr(sdt_pkg::OFF_COUNT, 32'h0000_f000);
    wr(sdt_pkg::OFF_CTRL, 32'h4b);
    idle(40);
    rd(sdt_pkg::OFF_STATUS); check(q & 32'h2, 32'h2);
    check({31'h0, irq}, 32'h1);
    rd(sdt_pkg::OFF_COUNT);
    check({31'h0, q[15:8] >= 8'he0}, 32'h1);
    wr(sdt_pkg::OFF_CTRL, 32'h0);
    wr(sdt_pkg::OFF_STATUS, 32'h7);
    rd(sdt_pkg::OFF_STATUS); check(q, 32'h0);
  endtask : t_high_half

  task automatic t_capture();
    wr(sdt_pkg::OFF_COUNT, 32'h0000_1234);
    wr(sdt_pkg::OFF_CTRL, 32'h80);
    @(posedge clk_i);
    comp <= 1'b1;
    idle(3);
    comp <= 1'b0;
    idle(2);
    rd(sdt_pkg::OFF_CAPTURE); check(q, 32'h0000_1234);
    rd(sdt_pkg::OFF_STATUS); check(q, 32'h4);
    wr(sdt_pkg::OFF_STATUS, 32'h4);
    rd(sdt_pkg::OFF_STATUS); check(q, 32'h0);
  endtask : t_capture

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  initial
  begin
    idle(12);
    rst_i <= 1'b0;
    idle(2);
    t_reset_values();
    t_clock_sources();
    t_low_overflow_irq();
    t_high_half();
    t_capture();
    wrap_up();
  end

  // Whole sequence needs about 700 cycles
  initial
  begin
    idle(20000);
    err_total++;
    wrap_up();
  end
endmodule : sdt_split_timer_bench
